// file: pietc_top.sv
// interrupt controller with eight single-move event channels
// assumes a cpu core that acks int_req and a memory side that
// performs each xfer_valid move within the stolen cycle
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
module pietc_top #(
  parameter int NSRC  = pietc_pkg::NSRC_DEF,
  parameter int NCHAN = pietc_pkg::NCHAN_DEF
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [pietc_pkg::AW-1:0]   paddr,
  input  wire logic [pietc_pkg::DW-1:0]   pwdata,
  output logic      [pietc_pkg::DW-1:0]   prdata,
  output logic                            pready,
  output logic                            pslverr,
  output logic                            irq,
  input  wire logic [pietc_pkg::NFAST-1:0] fast_ext_pin,
  input  wire logic [NSRC-pietc_pkg::NFAST-1:0] periph_req,
  input  wire logic [pietc_pkg::LVLW-1:0] cpu_level,
  input  wire logic                       trap_busy,
  output logic                            int_req,
  output logic      [pietc_pkg::VW-1:0]   int_vector,
  output logic      [pietc_pkg::TRW-1:0]  int_trap,
  output logic      [pietc_pkg::LVLW-1:0] int_level,
  input  wire logic                       int_ack,
  output logic                            xfer_valid,
  output logic      [15:0]                xfer_src,
  output logic      [15:0]                xfer_dst,
  output logic                            xfer_word,
  output logic                            cpu_steal
);
  import pietc_pkg::*;

  // ************************************************************
  // elaboration checks
  // ************************************************************
  // index fields are three bits wide, so eight is the ceiling
  if (NSRC <= NFAST || NSRC > 8) begin : g_bad_nsrc
    $error("NSRC out of range");
  end
  if (NCHAN < 1 || NCHAN > 8) begin : g_bad_nchan
    $error("NCHAN out of range");
  end
  // decision path fits under the latency maximum
  if (PIPE_CYC > LAT_MAX_CYC) begin : g_bad_lat
    $error("pipeline too slow");
  end

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [NSRC-1:0][CTL_W-1:0]  ctl;
    logic [NCHAN-1:0][DW-1:0]    ptr;
    logic [NCHAN-1:0][CFG_W-1:0] cfg;
    logic [7:0]                  stat;
    logic [7:0]                  mask;
    logic                        swt_pend;
    logic [TRW-1:0]              swt_num;
    logic [NFAST-1:0]            pin_q;
    pietc_st_e                   st;
    logic                        int_sw;
    logic [2:0]                  int_src;
    logic                        int_req;
    logic [VW-1:0]               int_vector;
    logic [TRW-1:0]              int_trap;
    logic [LVLW-1:0]             int_level;
    logic                        xfer_valid;
    logic [15:0]                 xfer_src;
    logic [15:0]                 xfer_dst;
    logic                        xfer_word;
    logic                        steal;
    logic [DW-1:0]               prdata;
    logic                        pready;
    logic                        pslverr;
    logic                        irq;
  } pietc_state_s;

  pietc_state_s r;
  pietc_state_s next_r;

  // vector location is four times the trap number
  function automatic logic [VW-1:0] vec_of(input logic [TRW-1:0] t);
    return {7'h00, t, 2'b00};
  endfunction : vec_of

  // ************************************************************
  // address decode
  // ************************************************************
  logic [2:0] reg_idx;
  logic [2:0] region;
  logic       hit;
  logic       acc;

  // region is the top three address bits, index the word within
  always_comb begin
    reg_idx = paddr[4:2];
    region  = paddr[7:5];
    acc     = psel & penable & r.pready;
    hit     = 1'b0;
    if (paddr[1:0] == 2'b00) begin
      if (region == A_CTL[7:5])
        hit = 32'(reg_idx) < NSRC;
      else if (region == A_PTR[7:5] || region == A_CFG[7:5])
        hit = 32'(reg_idx) < NCHAN;
      else if (region == A_SWT[7:5])
        hit = reg_idx <= A_STATE[4:2];
    end
  end

  // ************************************************************
  // arbitration
  // ************************************************************
  logic            best_ok;
  logic [2:0]      best_i;
  logic [LVLW-1:0] best_lvl;

  // lowest index wins a tie between equal levels
  always_comb begin
    best_ok  = 1'b0;
    best_i   = 3'h0;
    best_lvl = '0;
    for (int i = 0; i < NSRC; i++) begin
      // request, enable and level above cpu
      if (r.ctl[i][CTL_REQ] && r.ctl[i][CTL_EN] &&
          r.ctl[i][CTL_LVL+:LVLW] > cpu_level &&
          (!best_ok || r.ctl[i][CTL_LVL+:LVLW] > best_lvl)) begin
        best_ok  = 1'b1;
        best_i   = 3'(i);
        best_lvl = r.ctl[i][CTL_LVL+:LVLW];
      end
    end
  end

  // ************************************************************
  // next state
  // ************************************************************
  logic [2:0]       ch;
  logic [CFG_W-1:0] cf;
  logic [7:0]       done_set;
  logic [15:0]      step;
  logic             rise;
  logic             fall;

  always_comb begin
    next_r     = r;
    ch         = r.ctl[best_i][CTL_CH+:3];
    cf         = r.cfg[ch];
    done_set   = 8'h00;
    step       = cf[CFG_WORD] ? STEP_WORD : STEP_BYTE;
    rise       = 1'b0;
    fall       = 1'b0;
    next_r.pready     = 1'b0;
    next_r.pslverr    = 1'b0;
    next_r.xfer_valid = 1'b0;
    next_r.steal      = 1'b0;

    // bus answer one cycle into the access phase
    if (psel && penable && !r.pready) begin
      next_r.pready  = 1'b1;
      next_r.pslverr = !hit;
      next_r.prdata  = '0;
      if (hit) begin
        unique case (region)
          A_CTL[7:5]: next_r.prdata = {20'h0, r.ctl[reg_idx]};
          A_PTR[7:5]: next_r.prdata = r.ptr[reg_idx];
          A_CFG[7:5]: next_r.prdata = {21'h0, r.cfg[reg_idx]};
          default: begin
            unique case (reg_idx)
              A_SWT[4:2]:
                next_r.prdata = {24'h0, r.swt_pend, r.swt_num};
              A_STAT[4:2]: next_r.prdata = {24'h0, r.stat};
              A_MASK[4:2]: next_r.prdata = {24'h0, r.mask};
              default:
                next_r.prdata = {28'h0, r.int_sw, r.int_req,
                                 trap_busy, r.st == ST_INT};
            endcase
          end
        endcase
      end
    end

    // register writes commit at the edge pready is sampled high
    if (acc && pwrite && hit) begin
      unique case (region)
        A_CTL[7:5]: next_r.ctl[reg_idx] = pwdata[CTL_W-1:0];
        A_PTR[7:5]: next_r.ptr[reg_idx] = pwdata;
        A_CFG[7:5]: next_r.cfg[reg_idx] = pwdata[CFG_W-1:0];
        default: begin
          if (reg_idx == A_SWT[4:2]) begin
            next_r.swt_pend = 1'b1;
            next_r.swt_num  = pwdata[TRW-1:0];
          end
          if (reg_idx == A_MASK[4:2])
            next_r.mask = pwdata[7:0];
        end
      endcase
    end
    // status clears on read
    if (acc && !pwrite && hit && region == A_STAT[7:5] &&
        reg_idx == A_STAT[4:2])
      next_r.stat = 8'h00;

    unique case (r.st)
      ST_IDLE: begin
        // nothing starts while a hardware trap runs
        if (!trap_busy && r.swt_pend) begin
          // enters vector of the given trap number
          next_r.swt_pend   = 1'b0;
          next_r.int_req    = 1'b1;
          next_r.int_sw     = 1'b1;
          next_r.int_trap   = r.swt_num;
          next_r.int_vector = vec_of(r.swt_num);
          next_r.int_level  = cpu_level;
          next_r.st         = ST_INT;
        end else if (!trap_busy && best_ok && !r.xfer_valid) begin
          // gap after a steal keeps every stolen cycle a lone pulse
          // route by the engine bit of the source
          // empty counter on a non-continuous channel falls back to the vector path
          if (r.ctl[best_i][CTL_ENG] &&
              (cf[CFG_CONT] || cf[CFG_CNT+:CFG_CNTW] != 8'h00)) begin
            next_r.steal      = 1'b1;
            next_r.xfer_valid = 1'b1;
            next_r.xfer_src   = r.ptr[ch][15:0];
            next_r.xfer_dst   = r.ptr[ch][31:16];
            next_r.xfer_word  = cf[CFG_WORD];
            next_r.ctl[best_i][CTL_REQ] = 1'b0;
            if (cf[CFG_SRC])
              next_r.ptr[ch][15:0] = r.ptr[ch][15:0] + step;
            else
              next_r.ptr[ch][31:16] = r.ptr[ch][31:16] + step;
            if (!cf[CFG_CONT]) begin
              next_r.cfg[ch][CFG_CNT+:CFG_CNTW] =
                cf[CFG_CNT+:CFG_CNTW] - 8'h01;
              if (cf[CFG_CNT+:CFG_CNTW] == 8'h01)
                done_set[ch] = 1'b1;
            end
          end else begin
            next_r.int_req    = 1'b1;
            next_r.int_sw     = 1'b0;
            next_r.int_src    = best_i;
            next_r.int_trap   = FAST_TRAP + {4'h0, best_i};
            next_r.int_vector = vec_of(FAST_TRAP + {4'h0, best_i});
            next_r.int_level  = best_lvl;
            next_r.st         = ST_INT;
          end
        end
      end
      ST_INT: begin
        if (int_ack) begin
          next_r.int_req = 1'b0;
          next_r.st      = ST_IDLE;
          if (!r.int_sw)
            next_r.ctl[r.int_src][CTL_REQ] = 1'b0;
        end
      end
    endcase

    // edge detection on fast inputs, set wins over clear
    for (int f = 0; f < NFAST; f++) begin
      rise = fast_ext_pin[f] & ~r.pin_q[f];
      fall = ~fast_ext_pin[f] & r.pin_q[f];
      if ((rise && r.ctl[f][CTL_EDGE+1-1]) ||
          (fall && r.ctl[f][CTL_EDGE+1]))
        next_r.ctl[f][CTL_REQ] = 1'b1;
    end
    next_r.pin_q = fast_ext_pin;
    // peripheral request pulses
    for (int p = NFAST; p < NSRC; p++) begin
      if (periph_req[p-NFAST])
        next_r.ctl[p][CTL_REQ] = 1'b1;
    end

    // channel-finished events stick; set beats read clear
    next_r.stat = next_r.stat | done_set;
    next_r.irq  = |(next_r.stat & next_r.mask);
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ************************************************************
  // outputs, all straight from flops
  // ************************************************************
  assign prdata     = r.prdata;
  assign pready     = r.pready;
  assign pslverr    = r.pslverr;
  assign irq        = r.irq;
  assign int_req    = r.int_req;
  assign int_vector = r.int_vector;
  assign int_trap   = r.int_trap;
  assign int_level  = r.int_level;
  assign xfer_valid = r.xfer_valid;
  assign xfer_src   = r.xfer_src;
  assign xfer_dst   = r.xfer_dst;
  assign xfer_word  = r.xfer_word;
  assign cpu_steal  = r.steal;

endmodule : pietc_top

// file: pietc_pkg.sv
// constants for the prioritized interrupt and event transfer block
// assumes a 25 MHz pclk and an 8-bit APB byte address
package pietc_pkg;

  // ************************************************************
  // sizes
  // ************************************************************
  localparam int NSRC_DEF  = 8;
  localparam int NFAST     = 4;
  localparam int NCHAN_DEF = 8;
  localparam int AW        = 8;
  localparam int DW        = 32;
  localparam int LVLW      = 4;
  localparam int TRW       = 7;
  localparam int VW        = 16;

  // ************************************************************
  // register map, byte addresses
  // ************************************************************
  localparam logic [AW-1:0] A_CTL   = 8'h00;
  localparam logic [AW-1:0] A_PTR   = 8'h40;
  localparam logic [AW-1:0] A_CFG   = 8'h60;
  localparam logic [AW-1:0] A_SWT   = 8'h80;
  localparam logic [AW-1:0] A_STAT  = 8'h84;
  localparam logic [AW-1:0] A_MASK  = 8'h88;
  localparam logic [AW-1:0] A_STATE = 8'h8c;

  // ************************************************************
  // source control word fields
  // ************************************************************
  localparam int CTL_REQ  = 0;
  localparam int CTL_EN   = 1;
  localparam int CTL_LVL  = 2;
  localparam int CTL_ENG  = 6;
  localparam int CTL_CH   = 7;
  localparam int CTL_EDGE = 10;
  localparam int CTL_W    = 12;

  // channel config fields
  localparam int CFG_CNT  = 0;
  localparam int CFG_CNTW = 8;
  localparam int CFG_WORD = 8;
  localparam int CFG_SRC  = 9;
  localparam int CFG_CONT = 10;
  localparam int CFG_W    = 11;

  // edge select codes
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // ************************************************************
  // vectors and timing
  // ************************************************************
  localparam logic [TRW-1:0] FAST_TRAP = 7'h18;
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;
  localparam int CLK_NS     = 40;
  localparam int LAT_MIN_NS = 250;
  localparam int LAT_MAX_NS = 600;
  localparam int LAT_MIN_CYC = (LAT_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int LAT_MAX_CYC = LAT_MAX_NS / CLK_NS;
  localparam int PIPE_CYC    = 2;

  typedef enum logic [0:0] {ST_IDLE, ST_INT} pietc_st_e;

endpackage : pietc_pkg

// file: pietc_assertions.sv
// checker for the interrupt and event transfer block
// assumes pclk and presetn as the only clock and reset
`timescale 1ns/1ns
module pietc_chk (
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire logic                        trap_busy,
  input wire logic [pietc_pkg::LVLW-1:0]  cpu_level,
  input wire logic                        int_req,
  input wire logic [pietc_pkg::VW-1:0]    int_vector,
  input wire logic [pietc_pkg::TRW-1:0]   int_trap,
  input wire logic [pietc_pkg::LVLW-1:0]  int_level,
  input wire logic                        int_ack,
  input wire logic                        xfer_valid,
  input wire logic                        cpu_steal
);
  import pietc_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ************************************************************
  // bus and handshake
  // ************************************************************
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  pready_qual_a: assert property (pready |-> psel && penable && $past(penable))
    else $error("pready outside access phase");
  err_with_rdy_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  int_hold_a: assert property (
    int_req && !int_ack |=> int_req && $stable(int_vector))
    else $error("int_req or vector changed before ack");
  int_drop_a: assert property (int_req && int_ack |=> !int_req)
    else $error("int_req stayed after ack");
  // ************************************************************
  // service rules
  // ************************************************************
  vec_of_trap_a: assert property (
    int_req |-> int_vector == {7'h0, int_trap, 2'b00})
    else $error("vector not four times trap");
  steal_one_a: assert property (
    xfer_valid |-> cpu_steal ##1 !xfer_valid && !cpu_steal)
    else $error("engine service not a single stolen cycle");
  trap_block_a: assert property (
    $rose(int_req) || $rose(xfer_valid) |-> !$past(trap_busy))
    else $error("service started during hardware trap");
  level_above_a: assert property (
    $rose(int_req) |-> int_level >= $past(cpu_level))
    else $error("service level below cpu level");
  cover property (xfer_valid);
  cover property (int_req && int_ack);
  cover property (pready && pslverr);
endmodule : pietc_chk

bind pietc_top pietc_chk u_chk (.pclk, .presetn, .psel, .penable, .pready,
  .pslverr, .trap_busy, .cpu_level, .int_req, .int_vector, .int_trap,
  .int_level, .int_ack, .xfer_valid, .cpu_steal);

// file: pietc_cpu.sv
// cpu core model: acks vectored requests, counts stolen moves
// assumes int_req held until int_ack as the block promises
`timescale 1ns/1ns
module pietc_cpu (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       int_req,
  input  wire logic       xfer_valid,
  input  wire logic [2:0] ack_dly,
  output logic            int_ack,
  output logic [7:0]      moves
);
  logic [2:0] wait_cnt;
  // one-cycle ack after a set delay, so slow and prompt cpus both run
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      int_ack <= 1'b0;
      wait_cnt <= 3'h0;
      moves <= 8'h00;
    end else begin
      int_ack <= int_req && !int_ack && wait_cnt == ack_dly;
      wait_cnt <= (int_req && !int_ack) ? wait_cnt + 3'h1 : 3'h0;
      moves <= moves + {7'h0, xfer_valid};
    end
  end
endmodule : pietc_cpu

// file: pietc_tb.sv
// self-checking bench for the interrupt and event transfer block
// assumes the cpu model in pietc_cpu and default parameters
`timescale 1ns/1ns
module prioritized_interrupt_and_event_transfer_tb;
  import pietc_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic pready, pslverr, irq, int_req, int_ack, xfer_valid, xfer_word;
  logic cpu_steal, trap_busy = 0, rerr;
  logic [7:0] paddr = 0, moves;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0] fast_ext_pin = 0, periph_req = 0, cpu_level = 0, int_level;
  logic [15:0] int_vector, xfer_src, xfer_dst;
  logic [6:0] int_trap;
  logic [2:0] ack_dly = 0;
  int errors = 0, check_count = 0;
  always #20 pclk = !pclk;
  pietc_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .irq, .fast_ext_pin, .periph_req, .cpu_level,
    .trap_busy, .int_req, .int_vector, .int_trap, .int_level, .int_ack,
    .xfer_valid, .xfer_src, .xfer_dst, .xfer_word, .cpu_steal);
  pietc_cpu cpu (.clk(pclk), .rstn(presetn), .int_req, .xfer_valid, .ack_dly,
    .int_ack, .moves);
  // ************************************************************
  // shared tasks
  // ************************************************************
  task end_of_test;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", n, e, g);
      errors++;
    end
  endtask : chk
  task automatic wait_for(ref logic s, input logic v);
    for (int n = 0; s !== v; n++) begin
      if (n == 60) begin
        chk("wait", v, s);
        end_of_test();
      end
      @(posedge pclk);
    end
  endtask : wait_for
  // request held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    wait_for(pready, 1'b1);
    rd = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task cycles(input int n);
    repeat (n) @(posedge pclk);
  endtask : cycles
  task pin(input logic [3:0] v);
    @(posedge pclk);
    fast_ext_pin <= v;
  endtask : pin
  // wait for a vectored request, check it, let the cpu ack it
  task exp_int(input logic [15:0] v, input logic [6:0] t, input logic [3:0] l);
    wait_for(int_req, 1'b1);
    chk("vector", {16'h0, v}, {16'h0, int_vector});
    chk("trap", {25'h0, t}, {25'h0, int_trap});
    chk("level", {28'h0, l}, {28'h0, int_level});
    wait_for(int_req, 1'b0);
  endtask : exp_int
  task req4;
    @(posedge pclk);
    periph_req <= 4'h1;
    @(posedge pclk);
    periph_req <= 4'h0;
  endtask : req4
  // ************************************************************
  // scenarios
  // ************************************************************
  task t_regs;
    apb(0, A_CTL, 0);
    chk("ctl0 reset", 0, rd);
    apb(0, 8'h90, 0);
    chk("unmapped err", 1, {31'h0, rerr});
    $display("test regs done");
  endtask : t_regs
  task t_edges;
    int lat;
    apb(1, A_CTL, 32'h41e);
    pin(4'h1);
    // the request must show within the latency bound
    for (lat = 0; lat < LAT_MAX_CYC && int_req !== 1'b1; lat++)
      @(posedge pclk);
    chk("latency", 1, {31'h0, int_req});
    exp_int(16'h0060, 7'h18, 4'h7);
    apb(0, A_CTL, 0);
    chk("req cleared", 32'h41e, rd);
    ack_dly <= 3'h4;
    apb(1, A_CTL + 8'h8, 32'hc0a);
    pin(4'h5);
    exp_int(16'h0068, 7'h1a, 4'h2);
    pin(4'h1);
    exp_int(16'h0068, 7'h1a, 4'h2);
    $display("test edges done");
  endtask : t_edges
  task t_prio;
    cpu_level <= 4'h5;
    apb(1, A_CTL + 8'h4, 32'h816);
    pin(4'h3);
    pin(4'h1);
    cycles(10);
    chk("no preempt", 0, {31'h0, int_req});
    apb(0, A_CTL + 8'h4, 0);
    chk("fall flag", 32'h817, rd);
    cpu_level <= 4'h4;
    exp_int(16'h0064, 7'h19, 4'h5);
    cpu_level <= 4'h0;
    $display("test prio done");
  endtask : t_prio
  task t_engine;
    apb(1, A_CTL + 8'h10, 32'hce);
    apb(1, A_PTR + 8'h4, 32'h02000100);
    apb(1, A_CFG + 8'h4, 32'h302);
    apb(1, A_MASK, 32'h2);
    for (int k = 0; k < 2; k++) begin
      req4();
      wait_for(xfer_valid, 1'b1);
      chk("src", 32'h100 + 2 * k, {16'h0, xfer_src});
      chk("dst", 32'h200, {16'h0, xfer_dst});
      chk("word", 1, {31'h0, xfer_word & cpu_steal & !int_req});
    end
    cycles(3);
    chk("moves", 2, {24'h0, moves});
    chk("irq", 1, {31'h0, irq});
    apb(0, A_STAT, 0);
    chk("status", 2, rd);
    cycles(2);
    chk("irq clr", 0, {31'h0, irq});
    req4();
    exp_int(16'h0070, 7'h1c, 4'h3);
    chk("no move", 2, {24'h0, moves});
    $display("test engine done");
  endtask : t_engine
  task t_swtrap;
    trap_busy <= 1'b1;
    apb(1, A_SWT, 32'h33);
    cycles(8);
    chk("trap blocks", 0, {31'h0, int_req});
    trap_busy <= 1'b0;
    exp_int(16'h00cc, 7'h33, 4'h0);
    $display("test swtrap done");
  endtask : t_swtrap
  // continuous channel: byte moves, destination steps, count kept
  task t_cont;
    apb(1, A_CTL + 8'h14, 32'h14e);
    apb(1, A_PTR + 8'h8, 32'h04000300);
    apb(1, A_CFG + 8'h8, 32'h400);
    for (int k = 0; k < 2; k++) begin
      @(posedge pclk);
      periph_req <= 4'h2;
      @(posedge pclk);
      periph_req <= 4'h0;
      wait_for(xfer_valid, 1'b1);
      chk("cont src", 32'h300, {16'h0, xfer_src});
      chk("cont dst", 32'h400 + k, {16'h0, xfer_dst});
      chk("cont byte", 0, {31'h0, xfer_word});
    end
    apb(0, A_CFG + 8'h8, 0);
    chk("cont count", 32'h400, rd);
    chk("cont moves", 4, {24'h0, moves});
    chk("cont no int", 0, {31'h0, int_req});
    $display("test cont done");
  endtask : t_cont
  initial begin
    cycles(5);
    presetn <= 1'b1;
    t_regs();
    t_edges();
    t_prio();
    t_engine();
    t_swtrap();
    t_cont();
    end_of_test();
  end
endmodule : prioritized_interrupt_and_event_transfer_tb
